/* File: sbs_core.sv */
`timescale 1ns/1ps
`include "sbs_map.svh"

module sbs_core (
    input  wire logic        clk_sys,             // system clock
    input  wire logic        rst,                 // async reset, high
    input  wire logic        smb_clk,             // serial link clock
    input  wire logic        smb_data_in,         // serial data pin level
    output logic             smb_data_out,        // serial data drive value
    output logic             smb_data_oe_n,       // low while pulling data
    input  wire logic        standby_input_n,     // hardware standby, low
    input  wire logic        slave_addr_select_0, // address strap 0
    input  wire logic        slave_addr_select_1, // address strap 1
    output logic             adc_enable,          // converter running
    output logic       [2:0] adc_chan,            // channel in conversion
    input  wire logic        adc_done,            // channel sample ready
    input  wire logic [10:0] adc_sample,          // quarter degree, signed
    output logic             conv_busy,           // conversion in progress
    output logic             standby_active       // standby requested
);

    // ------------------------------------------------------------------
    // link domain: byte shifter clocked by the serial clock
    // ------------------------------------------------------------------
    logic [7:0] link_sh_r;

    // sampled on the rising serial edge; the system side reads it only
    // after a synchronised rising edge, while it is quasi-static
    always_ff @(posedge smb_clk or posedge rst) begin
        if (rst) begin
            link_sh_r <= 8'h00;
        end else begin
            link_sh_r <= {link_sh_r[6:0], smb_data_in};
        end
    end

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    logic [4:0] pin_raw;
    logic [4:0] pin_m_r;
    logic [4:0] pin_s_r;
    logic       scl_d_r;
    logic       sda_d_r;

    assign pin_raw = {slave_addr_select_1, slave_addr_select_0,
                      standby_input_n, smb_data_in, smb_clk};

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pin_m_r <= 5'h1f;
            pin_s_r <= 5'h1f;
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            pin_m_r <= pin_raw;
            pin_s_r <= pin_m_r;
            scl_d_r <= pin_s_r[0];
            sda_d_r <= pin_s_r[1];
        end
    end

    // bus condition decode
    logic scl_rise;
    logic scl_fall;
    logic start_ev;
    logic stop_ev;
    logic hw_standby_input_n;

    assign scl_rise = pin_s_r[0] & ~scl_d_r;
    assign scl_fall = ~pin_s_r[0] & scl_d_r;
    assign start_ev = pin_s_r[0] & scl_d_r & sda_d_r & ~pin_s_r[1];
    assign stop_ev  = pin_s_r[0] & scl_d_r & ~sda_d_r & pin_s_r[1];
    assign hw_standby_input_n  = ~pin_s_r[2];

    // ------------------------------------------------------------------
    // address strap capture
    // ------------------------------------------------------------------
    logic [1:0] pwr_cnt_r;
    logic       addr_cap_r;
    logic [1:0] my_sel_r;

    // waits for the synchronisers to fill, then freezes the straps
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pwr_cnt_r  <= 2'h0;
            addr_cap_r <= 1'b0;
            my_sel_r   <= 2'h0;
        end else if (!addr_cap_r) begin
            pwr_cnt_r <= pwr_cnt_r + 2'h1;
            if (pwr_cnt_r == `SBS_ADDR_WAIT) begin
                addr_cap_r <= 1'b1;
                my_sel_r   <= pin_s_r[4:3];
            end
        end
    end

    // ------------------------------------------------------------------
    // slave protocol engine
    // ------------------------------------------------------------------
    sbs_pkg::sbs_link_st_t lst_r;
    logic [2:0] bcnt_r;
    logic       ack_on_r;
    logic       rw_r;
    logic [7:0] tx_r;
    logic [7:0] ptr_r;
    logic [7:0] wr_byte_r;
    logic       wr_stb_r;
    logic       oe_n_r;
    logic       byte_done;
    logic       addr_hit;
    logic [7:0] rd_byte;

    assign byte_done = scl_rise && bcnt_r == 3'h7;
    assign addr_hit  = link_sh_r[7:1] == (`SBS_SLV_BASE | {5'h00, my_sel_r});

    // open drain: a one releases the line, a zero pulls it low
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            lst_r     <= sbs_pkg::L_IDLE;
            bcnt_r    <= 3'h0;
            ack_on_r  <= 1'b0;
            rw_r      <= 1'b0;
            tx_r      <= 8'h00;
            ptr_r     <= 8'h00;
            wr_byte_r <= 8'h00;
            wr_stb_r  <= 1'b0;
            oe_n_r    <= 1'b1;
        end else begin
            wr_stb_r <= 1'b0;
            if (scl_rise) begin
                bcnt_r <= bcnt_r + 3'h1;
            end
            if (start_ev) begin
                lst_r    <= sbs_pkg::L_ADDR;
                bcnt_r   <= 3'h0;
                ack_on_r <= 1'b0;
                oe_n_r   <= 1'b1;
            end else if (stop_ev) begin
                lst_r    <= sbs_pkg::L_IDLE;
                ack_on_r <= 1'b0;
                oe_n_r   <= 1'b1;
            end else begin
                case (lst_r)
                    sbs_pkg::L_ADDR: if (byte_done) begin
                        rw_r  <= link_sh_r[0];
                        lst_r <= addr_hit ? sbs_pkg::L_AACK
                                          : sbs_pkg::L_IDLE;
                    end
                    sbs_pkg::L_CMD: if (byte_done) begin
                        ptr_r <= link_sh_r;
                        lst_r <= sbs_pkg::L_CACK;
                    end
                    sbs_pkg::L_WR: if (byte_done) begin
                        wr_byte_r <= link_sh_r;
                        wr_stb_r  <= 1'b1;
                        lst_r     <= sbs_pkg::L_WACK;
                    end
                    sbs_pkg::L_AACK, sbs_pkg::L_CACK, sbs_pkg::L_WACK:
                    if (scl_fall) begin
                        if (!ack_on_r) begin
                            ack_on_r <= 1'b1;
                            oe_n_r   <= 1'b0;
                        end else begin
                            ack_on_r <= 1'b0;
                            bcnt_r   <= 3'h0;
                            if (lst_r == sbs_pkg::L_AACK && rw_r) begin
                                lst_r  <= sbs_pkg::L_RD;
                                tx_r   <= {rd_byte[6:0], 1'b0};
                                oe_n_r <= rd_byte[7];
                            end else begin
                                oe_n_r <= 1'b1;
                                lst_r  <= (lst_r == sbs_pkg::L_AACK)
                                          ? sbs_pkg::L_CMD
                                          : (lst_r == sbs_pkg::L_CACK)
                                          ? sbs_pkg::L_WR
                                          : sbs_pkg::L_IDLE;
                            end
                        end
                    end
                    sbs_pkg::L_RD: begin
                        if (byte_done) begin
                            lst_r <= sbs_pkg::L_RACK;
                        end else if (scl_fall) begin
                            oe_n_r <= tx_r[7];
                            tx_r   <= {tx_r[6:0], 1'b0};
                        end
                    end
                    sbs_pkg::L_RACK: begin
                        if (scl_fall) begin
                            oe_n_r <= 1'b1;
                        end else if (scl_rise) begin
                            lst_r <= sbs_pkg::L_IDLE;
                        end
                    end
                    sbs_pkg::L_IDLE: lst_r <= sbs_pkg::L_IDLE;
                    default:         lst_r <= sbs_pkg::L_IDLE;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // register decode; the link keeps serving in standby
    // ------------------------------------------------------------------
    logic       wr_cfg;
    logic       wr_one;
    logic       wr_thr;
    logic [7:0] thr_idx;
    logic [7:0] mem_rd;
    logic [7:0] cfg_r;
    logic       oneshot_r;
    logic [7:0] status_b;
    logic       adc_en_r;
    logic [4:0][7:0] temp_r;

    assign thr_idx = ptr_r - `SBS_PTR_THR_BASE;
    assign wr_cfg  = wr_stb_r && ptr_r == `SBS_PTR_CONFIG;
    assign wr_one  = wr_stb_r && ptr_r == `SBS_PTR_ONESHOT;
    assign wr_thr  = wr_stb_r && ptr_r >= `SBS_PTR_THR_BASE &&
                     ptr_r <= `SBS_PTR_THR_LAST;
    assign status_b = {adc_en_r, 7'h00};

    // read source select by the retained pointer
    assign rd_byte = (ptr_r < `SBS_PTR_STATUS) ? temp_r[ptr_r[2:0]] :
                     (ptr_r == `SBS_PTR_STATUS) ? status_b :
                     (ptr_r == `SBS_PTR_CONFIG) ? cfg_r :
                     (ptr_r >= `SBS_PTR_THR_BASE &&
                      ptr_r <= `SBS_PTR_THR_LAST) ? mem_rd : 8'h00;

    sbs_regmem u_thr (
        .clk_sys (clk_sys),
        .rst     (rst),
        .wr_en   (wr_thr),
        .wr_addr (thr_idx[3:0]),
        .wr_data (wr_byte_r),
        .rd_addr (thr_idx[3:0]),
        .rd_data (mem_rd)
    );

    // ------------------------------------------------------------------
    // standby and conversion requests
    // ------------------------------------------------------------------
    logic halt;
    logic commit;
    logic standby_input_n_r;

    // a one-shot may run under software stop, never under the pin
    assign halt = hw_standby_input_n | (cfg_r[`SBS_CFG_STOP_BIT] & ~oneshot_r);

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cfg_r     <= `SBS_CFG_RESET;
            oneshot_r <= 1'b0;
            standby_input_n_r    <= 1'b0;
        end else begin
            if (wr_cfg) begin
                cfg_r <= wr_byte_r;
            end
            // a new request wins over the end-of-cycle clear
            oneshot_r <= wr_one | (oneshot_r & ~commit);
            standby_input_n_r    <= hw_standby_input_n | cfg_r[`SBS_CFG_STOP_BIT];
        end
    end

    // ------------------------------------------------------------------
    // conversion sequencer
    // ------------------------------------------------------------------
    sbs_pkg::sbs_conv_st_t cst_r;
    logic [2:0] ch_r;
    logic [11:0] rsum;
    logic [9:0] rdeg;
    logic [7:0] rounded;
    logic [4:0][7:0] pend_r;

    // half degree added, then floor to whole degrees and clamp
    assign rsum    = {adc_sample[10], adc_sample} + `SBS_HALF_DEG;
    assign rdeg    = rsum[11:2];
    assign rounded = ($signed(rdeg) > $signed(`SBS_DEG_MAX)) ? 8'h7f :
                     ($signed(rdeg) < $signed(`SBS_DEG_MIN)) ? 8'hbf :
                     rdeg[7:0];
    assign commit  = cst_r == sbs_pkg::C_RUN && !halt && adc_done &&
                     ch_r == `SBS_LAST_CH;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cst_r    <= sbs_pkg::C_IDLE;
            adc_en_r <= 1'b0;
            ch_r     <= 3'h0;
        end else begin
            case (cst_r)
                sbs_pkg::C_IDLE: if (!halt) begin
                    cst_r    <= sbs_pkg::C_RUN;
                    adc_en_r <= 1'b1;
                    ch_r     <= 3'h0;
                end
                sbs_pkg::C_RUN: if (halt) begin
                    cst_r    <= sbs_pkg::C_IDLE;
                    adc_en_r <= 1'b0;
                    ch_r     <= 3'h0;
                end else if (adc_done) begin
                    if (ch_r == `SBS_LAST_CH) begin
                        cst_r    <= sbs_pkg::C_IDLE;
                        adc_en_r <= 1'b0;
                        ch_r     <= 3'h0;
                    end else begin
                        ch_r <= ch_r + 3'h1;
                    end
                end
                default: cst_r <= sbs_pkg::C_IDLE;
            endcase
        end
    end

    // pending results are published together; an abort drops them
    genvar g;
    generate
        for (g = 0; g < `SBS_NUM_CH; g++) begin : g_ch
            always_ff @(posedge clk_sys or posedge rst) begin
                if (rst) begin
                    pend_r[g] <= 8'h00;
                    temp_r[g] <= 8'h00;
                end else begin
                    if (cst_r == sbs_pkg::C_RUN && adc_done &&
                        ch_r == 3'(g)) begin
                        pend_r[g] <= rounded;
                    end
                    if (commit) begin
                        temp_r[g] <= (g == `SBS_NUM_CH - 1) ? rounded
                                                           : pend_r[g];
                    end
                end
            end
        end
    endgenerate

    // outputs straight from flops; the data drive value is tied low
    assign smb_data_out   = 1'b0 & oe_n_r;
    assign smb_data_oe_n  = oe_n_r;
    assign adc_enable     = adc_en_r;
    assign adc_chan       = ch_r;
    assign conv_busy      = adc_en_r;
    assign standby_active = standby_input_n_r;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    property p_standby_input_n_off;
        @(posedge clk_sys) disable iff (rst) halt |=> !adc_en_r;
    endproperty
    a_standby_input_n_off: assert property (p_standby_input_n_off)
        else $error("converter left running in standby");

    property p_pin_standby_input_n;
        @(posedge clk_sys) disable iff (rst)
            hw_standby_input_n && wr_one |=> !adc_en_r ##1 !adc_en_r;
    endproperty
    a_pin_standby_input_n: assert property (p_pin_standby_input_n)
        else $error("software request overrode standby pin");

    property p_standby_input_n_flag;
        @(posedge clk_sys) disable iff (rst) hw_standby_input_n |=> standby_input_n_r;
    endproperty
    a_standby_input_n_flag: assert property (p_standby_input_n_flag)
        else $error("standby pin not reflected");

    property p_keep_temp;
        @(posedge clk_sys) disable iff (rst) halt |=> $stable(temp_r);
    endproperty
    a_keep_temp: assert property (p_keep_temp)
        else $error("readings changed during standby");

    property p_restart;
        @(posedge clk_sys) disable iff (rst)
            cst_r == sbs_pkg::C_RUN && halt |=> ch_r == 3'h0;
    endproperty
    a_restart: assert property (p_restart)
        else $error("sequence not reset by standby");

    property p_publish;
        @(posedge clk_sys) disable iff (rst)
            commit |=> temp_r[4] == $past(rounded) && !adc_en_r;
    endproperty
    a_publish: assert property (p_publish)
        else $error("cycle results not published");

    property p_round;
        @(posedge clk_sys) disable iff (rst)
            adc_done && !halt && cst_r == sbs_pkg::C_RUN && ch_r == 3'h0
            && adc_sample == 11'h002 |=> pend_r[0] == 8'h01;
    endproperty
    a_round: assert property (p_round)
        else $error("half degree not rounded up");

    property p_ptr_keep;
        @(posedge clk_sys) disable iff (rst)
            lst_r != sbs_pkg::L_CMD |=> $stable(ptr_r);
    endproperty
    a_ptr_keep: assert property (p_ptr_keep)
        else $error("pointer lost outside command byte");

    property p_strap;
        @(posedge clk_sys) disable iff (rst) addr_cap_r |=> $stable(my_sel_r);
    endproperty
    a_strap: assert property (p_strap)
        else $error("address straps resampled");

    property p_ack;
        @(posedge clk_sys) disable iff (rst)
            lst_r == sbs_pkg::L_AACK && scl_fall && !ack_on_r && !start_ev
            && !stop_ev |=> !oe_n_r;
    endproperty
    a_ack: assert property (p_ack)
        else $error("address not acknowledged");

endmodule // sbs_core

/* File: sbs_map.svh */
`ifndef SBS_MAP_SVH
`define SBS_MAP_SVH

// ----------------------------------------------------------------------
// register pointers (command byte values)
// ----------------------------------------------------------------------
`define SBS_PTR_TEMP0      8'h00
`define SBS_PTR_STATUS     8'h05
`define SBS_PTR_CONFIG     8'h06
`define SBS_PTR_ONESHOT    8'h07
`define SBS_PTR_THR_BASE   8'h08
`define SBS_PTR_THR_LAST   8'h11

// ----------------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------------
`define SBS_CFG_STOP_BIT   6
`define SBS_CFG_RESET      8'h00
`define SBS_STS_BUSY_BIT   7
`define SBS_THR_HIGH_RST   8'h7f
`define SBS_THR_LOW_RST    8'hc9
`define SBS_NUM_CH         5
`define SBS_LAST_CH        3'h4
`define SBS_MEM_DEPTH      16
`define SBS_NUM_THR        10

// ----------------------------------------------------------------------
// slave address: base is arbitrary, select inputs fill bits 1:0
// ----------------------------------------------------------------------
`define SBS_SLV_BASE       7'h18

// ----------------------------------------------------------------------
// data format limits, 10-bit signed whole degrees
// ----------------------------------------------------------------------
`define SBS_DEG_MAX        10'h07f
`define SBS_DEG_MIN        10'h3bf
`define SBS_HALF_DEG       12'h002
`define SBS_ADDR_WAIT      2'h2

`endif

/* File: sbs_pkg.sv */
package sbs_pkg;

    // link protocol states
    typedef enum logic [3:0] {
        L_IDLE, L_ADDR, L_AACK, L_CMD, L_CACK, L_WR, L_WACK, L_RD, L_RACK
    } sbs_link_st_t;

    // converter sequencer states
    typedef enum logic {
        C_IDLE, C_RUN
    } sbs_conv_st_t;

endpackage

/* File: sbs_regmem.sv */
`timescale 1ns/1ps
`include "sbs_map.svh"

module sbs_regmem (
    input  wire logic       clk_sys,  // system clock
    input  wire logic       rst,      // async reset, high
    input  wire logic       wr_en,    // write strobe
    input  wire logic [3:0] wr_addr,  // write index
    input  wire logic [7:0] wr_data,  // write byte
    input  wire logic [3:0] rd_addr,  // read index
    output logic      [7:0] rd_data   // registered read byte
);

    logic [7:0] mem_r [`SBS_MEM_DEPTH];

    // ------------------------------------------------------------------
    // threshold store, first 10 entries: even high limit, odd low limit; the rest reset to zero
    // ------------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < `SBS_MEM_DEPTH; i++) begin : g_ent
            localparam logic [7:0] RST_V = (i >= `SBS_NUM_THR) ? 8'h00 :
                ((i % 2) == 0) ? `SBS_THR_HIGH_RST : `SBS_THR_LOW_RST;
            always_ff @(posedge clk_sys or posedge rst) begin
                if (rst) begin
                    mem_r[i] <= RST_V;
                end else if (wr_en && wr_addr == 4'(i)) begin
                    mem_r[i] <= wr_data;
                end
            end
        end
    endgenerate

    // read data registered, one cycle after the index
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rd_data <= 8'h00;
        end else begin
            rd_data <= mem_r[rd_addr];
        end
    end

endmodule // sbs_regmem

/* File: sbs_host.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------
// host model: bit-banged two-wire master
// ----------------------------------------------------------
module sbs_host (
    output logic       scl,    // link clock, idle high
    output logic       drv,    // data drive, 1 = released
    input  wire logic  sda,    // resolved data line
    output logic       rd_stb, // pulse per byte read
    output logic [7:0] rd_byte // byte read back
);
    // half bit of twelve 25 ns system periods: the slave samples scl through a sync
    localparam int HALF = 300;

    // clock stands high and data released outside frames
    initial begin
        scl = 1'b1;
        drv = 1'b1;
        rd_stb = 1'b0;
        rd_byte = 8'h00;
    end

    // one bit; data moves mid-low so no start or stop is faked
    task automatic bt(input logic b, output logic r);
        #(HALF/2) drv = b;
        #(HALF/2) scl = 1'b1;
        #HALF r = sda;
        scl = 1'b0;
    endtask

    // start, also used as repeated start
    task automatic start();
        #(HALF/2) drv = 1'b1;
        #(HALF/2) scl = 1'b1;
        #HALF drv = 1'b0;
        #HALF scl = 1'b0;
    endtask

    task automatic stop();
        #(HALF/2) drv = 1'b0;
        #(HALF/2) scl = 1'b1;
        #HALF drv = 1'b1;
        #HALF;
    endtask

    // byte out msb first, then the slave's ack slot
    task automatic tx(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bt(b[i], r);
        bt(1'b1, r);
        ack = ~r;
    endtask

    // byte in msb first, closed by a nack
    task automatic rx();
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bt(1'b1, r);
            rd_byte[i] = r;
        end
        bt(1'b1, r);
        rd_stb = 1'b1;
        #1 rd_stb = 1'b0;
    endtask

    // k: 0 write byte, 1 send byte, 2 read byte, 3 receive byte
    // single master on this link, so the pointer-only forms are safe
    task automatic xfer(input logic [6:0] a, input logic [1:0] k,
                        input logic [7:0] c, input logic [7:0] d,
                        output logic ack);
        logic x;
        start();
        tx({a, k == 2'd3}, ack);
        if (k != 2'd3)
            tx(c, x);
        if (k == 2'd0)
            tx(d, x);
        if (k == 2'd2) begin
            start();
            tx({a, 1'b1}, x);
        end
        if (k[1])
            rx();
        stop();
    endtask
endmodule // sbs_host

/* File: smbus_sensor_standby_interface_bench.sv */
`timescale 1ns/1ps
`include "sbs_map.svh"
// ----------------------------------------------------------
// bench: link, converter sequencing and standby
// ----------------------------------------------------------
module smbus_sensor_standby_interface_bench;
    logic        clk_sys = 1'b0, rst = 1'b1, standby_input_n_n = 1'b1, hold = 1'b1;
    logic        sel0 = 1'b0, sel1 = 1'b0, done = 1'b0;
    logic [10:0] sample = 11'h000;
    logic        scl, drv, rd_stb, oe_n, dout, en, busy, sb, ack;
    logic [7:0]  rd_byte, lat [5], pend [5], exp_q [$];
    logic [2:0]  chan;
    logic [6:0]  addr;
    logic [7:0]  tv;
    int          err_count = 0, checks = 0, ncyc = 0;
    wire         sda = drv & (oe_n | dout); // pulled-up open drain

    always #12.5 clk_sys = ~clk_sys;

    sbs_core i_dut (.clk_sys(clk_sys), .rst(rst), .smb_clk(scl),
        .smb_data_in(sda), .smb_data_out(dout), .smb_data_oe_n(oe_n),
        .standby_input_n(standby_input_n_n), .slave_addr_select_0(sel0),
        .slave_addr_select_1(sel1), .adc_enable(en), .adc_chan(chan),
        .adc_done(done), .adc_sample(sample), .conv_busy(busy),
        .standby_active(sb));
    sbs_host i_host (.scl(scl), .drv(drv), .sda(sda), .rd_stb(rd_stb),
        .rd_byte(rd_byte));

    // quarter degrees to rounded, clamped whole degrees
    function automatic logic [7:0] deg(input logic signed [10:0] s);
        int v;
        v = (int'(s) + 2) >>> 2;
        v = (v > 127) ? 127 : (v < -65) ? -65 : v;
        return v[7:0];
    endfunction

    task automatic cmp(input string n, input logic [7:0] e,
                       input logic [7:0] g);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic tmo(input logic ok, input string n);
        if (ok !== 1'b1) begin
            err_count++;
            $display("[ERR] %s expected 1 seen 0", n);
            end_of_test();
        end
    endtask

    // note the expected byte, then run the read
    task automatic rd(input logic [1:0] k, input logic [7:0] c,
                      input logic [7:0] e);
        exp_q.push_back(e);
        i_host.xfer(addr, k, c, 8'h00, ack);
    endtask

    task automatic wr(input logic [7:0] c, input logic [7:0] d);
        i_host.xfer(addr, 2'd0, c, d, ack);
        cmp("write ack", 8'h01, {7'h00, ack});
    endtask

    // each byte read back is held against the oldest note
    always @(posedge rd_stb)
        cmp("read byte", exp_q.pop_front(), rd_byte);

    // front end: slow random samples; a full set is what gets published
    always @(negedge clk_sys) begin
        logic go;
        go = en === 1'b1 && !hold && standby_input_n_n && $urandom_range(3) == 0;
        done = go;
        if (go) begin
            // first cycle opens on an exact half degree on channel 0
            sample = (chan == 3'd0 && ncyc == 0) ? 11'h002
                                                 : 11'($urandom);
            pend[chan] = deg(sample);
            if (chan == 3'd4) begin
                lat = pend;
                ncyc++;
            end
        end
    end

    initial begin
        void'($urandom(11));
        {sel1, sel0} = 2'($urandom);
        addr = `SBS_SLV_BASE | {5'h00, sel1, sel0};
        repeat (16) @(negedge clk_sys);
        rst = 1'b0;
        repeat (10) @(negedge clk_sys);
        sel0 = ~sel0; // straps move after capture
        i_host.xfer(addr ^ 7'h01, 2'd0, `SBS_PTR_CONFIG, 8'h40, ack);
        cmp("moved address ack", 8'h00, {7'h00, ack});
        rd(2'd2, `SBS_PTR_CONFIG, `SBS_CFG_RESET);
        $display("test address done");
        hold = 1'b0;
        for (int i = 0; i < 4000 && ncyc < 2; i++) @(negedge clk_sys);
        tmo(ncyc >= 2, "conversion cycles");
        hold = 1'b1; // leaves a cycle hanging, busy
        rd(2'd2, `SBS_PTR_STATUS, 8'h80);
        for (int i = 0; i < 5; i++)
            rd(2'd2, `SBS_PTR_TEMP0 + 8'(i), lat[i]);
        rd(2'd3, 8'h00, lat[4]);
        i_host.xfer(addr, 2'd1, `SBS_PTR_TEMP0 + 8'd2, 8'h00, ack);
        rd(2'd3, 8'h00, lat[2]);
        tv = 8'($urandom);
        rd(2'd2, `SBS_PTR_THR_BASE, `SBS_THR_HIGH_RST);
        rd(2'd2, `SBS_PTR_THR_BASE + 8'd1, `SBS_THR_LOW_RST);
        wr(`SBS_PTR_THR_LAST, tv);
        rd(2'd2, `SBS_PTR_THR_LAST, tv);
        $display("test readings done");
        wr(`SBS_PTR_CONFIG, 8'h40);
        cmp("standby flag", 8'h01, {7'h00, sb});
        hold = 1'b0;
        repeat (60) begin
            @(negedge clk_sys);
            cmp("converter", 8'h00, {7'h00, en});
        end
        rd(2'd2, `SBS_PTR_TEMP0 + 8'd1, lat[1]);
        rd(2'd2, `SBS_PTR_CONFIG, 8'h40);
        rd(2'd2, `SBS_PTR_STATUS, 8'h00);
        // a one-shot runs one full cycle under software stop
        wr(`SBS_PTR_ONESHOT, 8'h01);
        for (int i = 0; i < 4000 && ncyc < 3; i++) @(negedge clk_sys);
        tmo(ncyc >= 3, "one-shot cycle");
        repeat (4) @(negedge clk_sys);
        cmp("one-shot stops", 8'h00, {7'h00, en});
        rd(2'd2, `SBS_PTR_TEMP0 + 8'd3, lat[3]);
        $display("test stop bit done");
        wr(`SBS_PTR_CONFIG, 8'h00);
        for (int i = 0; i < 4000 && chan != 3'd2; i++) @(negedge clk_sys);
        tmo(chan == 3'd2, "channel two");
        standby_input_n_n = 1'b0;
        for (int i = 0; i < 20 && en !== 1'b0; i++) @(negedge clk_sys);
        tmo(en === 1'b0, "abort on pin");
        cmp("abort channel", 8'h00, {5'h00, chan});
        cmp("pin standby flag", 8'h01, {7'h00, sb});
        wr(`SBS_PTR_ONESHOT, 8'h01);
        repeat (60) begin
            @(negedge clk_sys);
            cmp("pin overrides", 8'h00, {7'h00, en});
        end
        rd(2'd2, `SBS_PTR_TEMP0 + 8'd2, lat[2]);
        standby_input_n_n = 1'b1;
        for (int i = 0; i < 40 && en !== 1'b1; i++) @(negedge clk_sys);
        tmo(en === 1'b1, "resume");
        cmp("resume channel", 8'h00, {5'h00, chan});
        cmp("busy", 8'h01, {7'h00, busy});
        $display("test pin standby done");
        cmp("notes left", 8'h00, 8'(exp_q.size()));
        end_of_test();
    end
endmodule // smbus_sensor_standby_interface_bench
